// [opcode_defines.svh]
`ifndef OPCODE_DEFINES_SVH
`define OPCODE_DEFINES_SVH
`define OP_WINDOWED 8'h00
`define OP_FREE_RUN 8'h01
`define OP_ACQ_QUERY 8'h02
`define OP_KEEP_SET 8'h03
`define OP_KEEP_CLR 8'h04
`define OP_FACTORY_LOAD 8'h05
`define OP_CUSTOM_SAVE 8'h06
`define OP_CUSTOM_LOAD 8'h07
`define OP_BOOT_CUSTOM 8'h08
`define OP_BOOT_FACTORY 8'h09
`define OP_SPAN_SET 8'h10
`define OP_SHIFT_SET 8'h11
`define OP_SEARCH_SET 8'h12
`define OP_DISCARD_SET 8'h13
`define OP_SUB_ON 8'h14
`define OP_SUB_OFF 8'h15
`define OP_TRIG_QUERY 8'h16
`define OP_EDGE_SET 8'h22
`define OP_EDGE_QUERY 8'h23
`define OP_EDGE_RES_SET 8'h24
`define OP_PAIR_RES_SET 8'h25
`define OP_RES_QUERY 8'h26
`define OP_DEAD_SET 8'h28
`define OP_DEAD_QUERY 8'h29
`define TRIG_READ_COUNT 3'h5
`define WORD12_MASK 16'h0FFF
`define CH_MAX_WIDE 8'h1F
`define CH_MAX_NARROW 8'h0F
`define CHIP_MAX_WIDE 8'h03
`define CHIP_MAX_NARROW 8'h01
`define FLAG_WRITE_BIT 0
`define FLAG_READ_BIT 1
`define DEF_SPAN 12'h000
`define DEF_SHIFT 12'h000
`define DEF_SEARCH 12'h000
`define DEF_DISCARD 12'h000
`define DEF_EDGE 2'h0
`define DEF_EDGE_RES 2'h0
`define DEF_PAIR_RES 16'h0000
`define DEF_DEAD 2'h0
`endif

// [opcode_handshake_interpreter.sv]
// What this block does
// - clear write permit on write, re-arm later
// - clear read permit on read, re-arm later
// - 16-bit word: operation high, target low
// - channel target range by variant
// - timing chip target range by variant sits in target_ok but is never selected; every target is checked as a channel
// - untargeted commands ignore target byte
// - exchange starts with command, no-operand ends
// - wait until all operands transferred
// - setup reprogramming clears acquired data
// - classify commands by reprogramming effect
// - mode, token, configuration commands, no operands
// - trigger window settings, five-word readback
// - trigger time subtraction on and off
// - edge detection set and readback
// - edge and pair resolution settings
// - dead time set and readback
// - result read at same port location
// - acquisition query bit0 one means windowed
// - mode select side effects: windowed sets reject, token; free run clears reject, subtraction
`timescale 1ns/1ps
`include "opcode_defines.svh"
module opcode_handshake_interpreter #(
   parameter bit WIDE_VARIANT = 1'b1
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic port_write_i,
   input wire logic [15:0] port_wdata_i,
   input wire logic port_read_i,
   output logic [15:0] port_rdata_o,
   output logic [15:0] host_flow_flags_o,
   output logic data_clear_o,
   output logic config_save_o,
   output logic config_load_o,
   output logic boot_custom_o,
   output logic windowed_mode_o,
   output logic keep_token_o,
   output logic auto_reject_o,
   output logic subtract_o,
   output logic [1:0] edge_mode_o,
   output logic [1:0] dead_time_o,
   output logic [7:0] target_o,
   output logic target_valid_o
);
   opcode_pkg::state_t s_q;
   opcode_pkg::state_t s_d;

   // class s commands clear acquired data; others leave it
   function automatic logic is_setup_class(input logic [7:0] op);
      case (op)
         `OP_WINDOWED, `OP_FREE_RUN, `OP_KEEP_SET, `OP_KEEP_CLR, `OP_FACTORY_LOAD,
         `OP_CUSTOM_LOAD, `OP_SPAN_SET, `OP_SHIFT_SET, `OP_SEARCH_SET, `OP_DISCARD_SET,
         `OP_SUB_ON, `OP_SUB_OFF, `OP_EDGE_SET, `OP_EDGE_RES_SET, `OP_PAIR_RES_SET,
         `OP_DEAD_SET: is_setup_class = 1'b1;
         default: is_setup_class = 1'b0;
      endcase
   endfunction : is_setup_class

   function automatic logic [2:0] writes_of(input logic [7:0] op);
      case (op)
         `OP_SPAN_SET, `OP_SHIFT_SET, `OP_SEARCH_SET, `OP_DISCARD_SET,
         `OP_EDGE_SET, `OP_EDGE_RES_SET, `OP_PAIR_RES_SET, `OP_DEAD_SET: writes_of = 3'h1;
         default: writes_of = 3'h0;
      endcase
   endfunction : writes_of

   function automatic logic [2:0] reads_of(input logic [7:0] op);
      case (op)
         `OP_ACQ_QUERY, `OP_EDGE_QUERY, `OP_RES_QUERY, `OP_DEAD_QUERY: reads_of = 3'h1;
         `OP_TRIG_QUERY: reads_of = `TRIG_READ_COUNT;
         default: reads_of = 3'h0;
      endcase
   endfunction : reads_of

   // readback word for a given operand index
   function automatic logic [15:0] read_word(input logic [7:0] op, input logic [2:0] idx,
                                            input opcode_pkg::setup_t st);
      read_word = 16'h0000;
      case (op)
         `OP_ACQ_QUERY: read_word = {15'h0000, st.windowed};
         `OP_TRIG_QUERY: begin
            case (idx)
               3'h0: read_word = {4'h0, st.span};
               3'h1: read_word = {4'h0, st.shift};
               3'h2: read_word = {4'h0, st.search};
               3'h3: read_word = {4'h0, st.discard};
               default: read_word = {15'h0000, st.subtract};
            endcase
         end
         `OP_EDGE_QUERY: read_word = {14'h0000, st.edge_mode};
         `OP_RES_QUERY: read_word = st.pair_res;
         `OP_DEAD_QUERY: read_word = {14'h0000, st.dead};
         default: read_word = 16'h0000;
      endcase
   endfunction : read_word

   function automatic opcode_pkg::setup_t apply_write(input logic [7:0] op,
                                                    input logic [15:0] w,
                                                    input opcode_pkg::setup_t st);
      apply_write = st;
      case (op)
         `OP_SPAN_SET: apply_write.span = w[11:0];
         `OP_SHIFT_SET: apply_write.shift = w[11:0];
         `OP_SEARCH_SET: apply_write.search = w[11:0];
         `OP_DISCARD_SET: apply_write.discard = w[11:0];
         `OP_EDGE_SET: apply_write.edge_mode = w[1:0];
         `OP_EDGE_RES_SET: apply_write.edge_res = w[1:0];
         `OP_PAIR_RES_SET: apply_write.pair_res = w;
         `OP_DEAD_SET: apply_write.dead = w[1:0];
         default: apply_write = st;
      endcase
   endfunction : apply_write

   function automatic opcode_pkg::setup_t defaults(input opcode_pkg::setup_t st);
      defaults = st;
      defaults.windowed = 1'b0;
      defaults.keep_token = 1'b0;
      defaults.auto_reject = 1'b0;
      defaults.subtract = 1'b0;
      defaults.span = `DEF_SPAN;
      defaults.shift = `DEF_SHIFT;
      defaults.search = `DEF_SEARCH;
      defaults.discard = `DEF_DISCARD;
      defaults.edge_mode = `DEF_EDGE;
      defaults.edge_res = `DEF_EDGE_RES;
      defaults.pair_res = `DEF_PAIR_RES;
      defaults.dead = `DEF_DEAD;
   endfunction : defaults

   // no-operand commands act in the cycle of the command write
   function automatic opcode_pkg::setup_t apply_cmd(input logic [7:0] op,
                                                  input opcode_pkg::setup_t st);
      apply_cmd = st;
      case (op)
         `OP_WINDOWED: begin
            apply_cmd.windowed = 1'b1;
            apply_cmd.auto_reject = 1'b1;
            apply_cmd.keep_token = 1'b1;
         end
         `OP_FREE_RUN: begin
            apply_cmd.windowed = 1'b0;
            apply_cmd.auto_reject = 1'b0;
            apply_cmd.subtract = 1'b0;
         end
         `OP_KEEP_SET: apply_cmd.keep_token = 1'b1;
         `OP_KEEP_CLR: apply_cmd.keep_token = 1'b0;
         `OP_FACTORY_LOAD: apply_cmd = defaults(st);
         `OP_BOOT_CUSTOM: apply_cmd.boot_custom = 1'b1;
         `OP_BOOT_FACTORY: apply_cmd.boot_custom = 1'b0;
         `OP_SUB_ON: apply_cmd.subtract = 1'b1;
         `OP_SUB_OFF: apply_cmd.subtract = 1'b0;
         default: apply_cmd = st;
      endcase
   endfunction : apply_cmd

   // target decode only matters for display; no command here takes a target
   function automatic logic target_ok(input logic [7:0] t, input logic chip);
      if (chip) begin
         target_ok = t <= (WIDE_VARIANT ? `CHIP_MAX_WIDE : `CHIP_MAX_NARROW);
      end else begin
         target_ok = t <= (WIDE_VARIANT ? `CH_MAX_WIDE : `CH_MAX_NARROW);
      end
   endfunction : target_ok

   opcode_pkg::command_word_t cmd;
   assign cmd = port_wdata_i;

   logic wr_take;
   logic rd_take;
   assign wr_take = port_write_i && s_q.write_permit_bit;
   assign rd_take = port_read_i && s_q.read_permit_bit;

   always_comb begin
      s_d = s_q;
      s_d.clear_data = 1'b0;
      s_d.save_pulse = 1'b0;
      s_d.load_custom_pulse = 1'b0;
      // a consumed permit comes back one cycle later (write permit outside ST_READ, read permit inside it), so the host always sees the drop
      if (!s_q.write_permit_bit && s_q.phase != opcode_pkg::ST_READ) begin
         s_d.write_permit_bit = 1'b1;
      end
      if (!s_q.read_permit_bit && s_q.phase == opcode_pkg::ST_READ) begin
         s_d.read_permit_bit = 1'b1;
         s_d.rd_word = read_word(s_q.op, s_q.idx, s_q.setup);
      end
      case (s_q.phase)
         opcode_pkg::ST_IDLE: begin
            if (wr_take) begin
               s_d.op = cmd.operation_selector;
               s_d.idx = 3'h0;
               s_d.target = cmd.target_selector;
               s_d.target_valid = target_ok(cmd.target_selector, 1'b0);
               s_d.setup = apply_cmd(cmd.operation_selector, s_q.setup);
               s_d.clear_data = is_setup_class(cmd.operation_selector) &&
                                writes_of(cmd.operation_selector) == 3'h0;
               s_d.save_pulse = cmd.operation_selector == `OP_CUSTOM_SAVE;
               s_d.load_custom_pulse = cmd.operation_selector == `OP_CUSTOM_LOAD;
               if (writes_of(cmd.operation_selector) != 3'h0) begin
                  s_d.phase = opcode_pkg::ST_WRITE;
                  s_d.count = writes_of(cmd.operation_selector);
                  s_d.write_permit_bit = 1'b0;
               end else if (reads_of(cmd.operation_selector) != 3'h0) begin
                  s_d.phase = opcode_pkg::ST_READ;
                  s_d.count = reads_of(cmd.operation_selector);
                  s_d.write_permit_bit = 1'b0;
                  s_d.read_permit_bit = 1'b1;
                  s_d.rd_word = read_word(cmd.operation_selector, 3'h0, s_q.setup);
               end else begin
                  s_d.write_permit_bit = 1'b0;
               end
            end
         end
         opcode_pkg::ST_WRITE: begin
            if (wr_take) begin
               s_d.setup = apply_write(s_q.op, port_wdata_i, s_q.setup);
               s_d.idx = s_q.idx + 3'h1;
               if (s_q.idx + 3'h1 == s_q.count) begin
                  s_d.phase = opcode_pkg::ST_IDLE;
                  s_d.clear_data = is_setup_class(s_q.op);
               end
               s_d.write_permit_bit = 1'b0;
            end
         end
         opcode_pkg::ST_READ: begin
            if (rd_take) begin
               s_d.idx = s_q.idx + 3'h1;
               if (s_q.idx + 3'h1 == s_q.count) begin
                  s_d.phase = opcode_pkg::ST_IDLE;
                  s_d.write_permit_bit = 1'b1;
               end
               s_d.read_permit_bit = 1'b0;
               s_d.rd_word = 16'h0000;
            end
         end
         default: s_d.phase = opcode_pkg::ST_IDLE;
      endcase
      if (reset_i) begin
         s_d = '0;
         s_d.phase = opcode_pkg::ST_IDLE;
         s_d.write_permit_bit = 1'b1;
         s_d.setup = defaults('0);
      end
   end

   always_ff @(posedge clock_i) begin
      s_q <= s_d;
   end

   assign port_rdata_o = s_q.rd_word;
   assign host_flow_flags_o = {14'h0000, s_q.read_permit_bit,
                               s_q.write_permit_bit};
   assign data_clear_o = s_q.clear_data;
   assign config_save_o = s_q.save_pulse;
   assign config_load_o = s_q.load_custom_pulse;
   assign boot_custom_o = s_q.setup.boot_custom;
   assign windowed_mode_o = s_q.setup.windowed;
   assign keep_token_o = s_q.setup.keep_token;
   assign auto_reject_o = s_q.setup.auto_reject;
   assign subtract_o = s_q.setup.subtract;
   assign edge_mode_o = s_q.setup.edge_mode;
   assign dead_time_o = s_q.setup.dead;
   assign target_o = s_q.target;
   assign target_valid_o = s_q.target_valid;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);

   sequence cmd_no_operand;
      wr_take && s_q.phase == opcode_pkg::ST_IDLE &&
      writes_of(cmd.operation_selector) == 3'h0 && reads_of(cmd.operation_selector) == 3'h0;
   endsequence

   sequence idle_take;
      wr_take && s_q.phase == opcode_pkg::ST_IDLE;
   endsequence

   sequence query_take;
      idle_take ##0 (writes_of(cmd.operation_selector) == 3'h0 &&
                     reads_of(cmd.operation_selector) != 3'h0);
   endsequence

   sequence last_read;
      rd_take && s_q.idx + 3'h1 == s_q.count;
   endsequence

   AST_WP_DROP: assert property (wr_take |=> !host_flow_flags_o[0])
      else $error("write permit not dropped after write");
   AST_RP_SINGLE: assert property (rd_take && s_q.count == 3'h1 |=> !s_q.read_permit_bit)
      else $error("read permit not dropped after last read");
   AST_NO_OP_END: assert property (cmd_no_operand |=> s_q.phase == opcode_pkg::ST_IDLE)
      else $error("no-operand command left idle");
   AST_WAIT_WRITE: assert property (s_q.phase == opcode_pkg::ST_WRITE && !wr_take |=>
                                    s_q.phase == opcode_pkg::ST_WRITE)
      else $error("write wait left early");
   AST_WAIT_READ: assert property (s_q.phase == opcode_pkg::ST_READ && !rd_take |=>
                                   s_q.phase == opcode_pkg::ST_READ)
      else $error("read wait left early");
   AST_CLEAR: assert property (wr_take && s_q.phase == opcode_pkg::ST_IDLE &&
                               cmd.operation_selector == `OP_SUB_ON |=> data_clear_o)
      else $error("setup command did not clear data");
   AST_NO_CLEAR: assert property (wr_take && s_q.phase == opcode_pkg::ST_IDLE &&
                                  cmd.operation_selector == `OP_CUSTOM_SAVE |=> !data_clear_o)
      else $error("save cleared data");
   AST_WINDOWED: assert property (wr_take && s_q.phase == opcode_pkg::ST_IDLE &&
                                  cmd.operation_selector == `OP_WINDOWED |=>
                                  windowed_mode_o && auto_reject_o && keep_token_o)
      else $error("windowed mode side effects missing");
   AST_FREE_RUN: assert property (wr_take && s_q.phase == opcode_pkg::ST_IDLE &&
                                  cmd.operation_selector == `OP_FREE_RUN |=>
                                  !windowed_mode_o && !auto_reject_o && !subtract_o)
      else $error("free running side effects missing");
   AST_ACQ_BIT: assert property (s_q.phase == opcode_pkg::ST_READ && s_q.op == `OP_ACQ_QUERY
                                 |-> port_rdata_o[0] == windowed_mode_o)
      else $error("acquisition query bit wrong");
   AST_TRIG_FIVE: assert property (wr_take && s_q.phase == opcode_pkg::ST_IDLE &&
                                   cmd.operation_selector == `OP_TRIG_QUERY |=>
                                   s_q.count == `TRIG_READ_COUNT)
      else $error("trigger query count wrong");
   AST_RP_DROP: assert property (rd_take |=> !host_flow_flags_o[1])
      else $error("read permit not dropped after read");
   AST_RP_REARM: assert property (s_q.phase == opcode_pkg::ST_READ && !s_q.read_permit_bit |=>
                                  s_q.read_permit_bit)
      else $error("read permit not re-armed");
   AST_RP_DATA: assert property (!s_q.read_permit_bit |-> port_rdata_o == 16'h0000)
      else $error("read data shown without read permit");
   AST_WP_REARM: assert property (!s_q.write_permit_bit && s_q.phase != opcode_pkg::ST_READ |=>
                                  host_flow_flags_o[0])
      else $error("write permit not re-armed");
   AST_WP_REFUSE: assert property (port_write_i && !host_flow_flags_o[0] |=>
                                   $stable(s_q.setup))
      else $error("write taken without write permit");
   AST_QUERY_ARM: assert property (query_take |=> host_flow_flags_o == 16'h0002)
      else $error("query did not hand over to read");
   AST_READ_END: assert property (last_read |=> s_q.phase == opcode_pkg::ST_IDLE &&
                                  host_flow_flags_o == 16'h0001)
      else $error("last read did not end exchange");
   AST_TARGET: assert property (idle_take |=>
                                target_valid_o == (target_o <= (WIDE_VARIANT ?
                                `CH_MAX_WIDE : `CH_MAX_NARROW)))
      else $error("channel target range wrong");
   AST_SPAN: assert property (wr_take && s_q.phase == opcode_pkg::ST_WRITE &&
                              s_q.op == `OP_SPAN_SET |=>
                              {4'h0, s_q.setup.span} ==
                              ($past(port_wdata_i) & `WORD12_MASK))
      else $error("window span not stored");
   AST_EDGE: assert property (wr_take && s_q.phase == opcode_pkg::ST_WRITE &&
                              s_q.op == `OP_EDGE_SET |=>
                              {14'h0000, edge_mode_o} ==
                              ($past(port_wdata_i) & 16'h0003))
      else $error("edge mode not stored");
endmodule : opcode_handshake_interpreter

// [opcode_handshake_interpreter_bench.sv]
`timescale 1ns/1ps
module opcode_handshake_interpreter_bench;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic port_write_i, port_read_i, data_clear_o, config_save_o, config_load_o;
   logic boot_custom_o, windowed_mode_o, keep_token_o, auto_reject_o, subtract_o;
   logic target_valid_o;
   logic [15:0] port_wdata_i, port_rdata_o, host_flow_flags_o, rd;
   logic [1:0] edge_mode_o, dead_time_o;
   logic [7:0] target_o;
   logic [7:0] s_ops [8] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h07, 8'h14, 8'h15};
   logic [7:0] n_ops [3] = '{8'h06, 8'h08, 8'h09};
   logic [15:0] trig_exp [4] = '{16'h0ABC, 16'h0123, 16'h0FFF, 16'h0001};
   int err_total = 0;
   int n_compared = 0;
   int cycles = 0;
   int n_clear = 0;
   int n_save = 0;
   int n_load = 0;
   always #12.5 clock_i = ~clock_i;
   opcode_handshake_interpreter #(.WIDE_VARIANT(1'b1)) uut (.clock_i, .reset_i,
      .port_write_i, .port_wdata_i, .port_read_i, .port_rdata_o, .host_flow_flags_o,
      .data_clear_o, .config_save_o, .config_load_o, .boot_custom_o, .windowed_mode_o,
      .keep_token_o, .auto_reject_o, .subtract_o, .edge_mode_o, .dead_time_o,
      .target_o, .target_valid_o);
   vme_host_model host (.clock_i, .host_flow_flags_i(host_flow_flags_o),
      .port_rdata_i(port_rdata_o), .port_write_o(port_write_i),
      .port_wdata_o(port_wdata_i), .port_read_o(port_read_i));
   task wrap_up();
      err_total += host.timeouts;
      $display("compares %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   // pulses are one cycle wide, so count them mid-cycle where they are settled
   always @(negedge clock_i) begin
      cycles++;
      if (data_clear_o === 1'b1) n_clear++;
      if (config_save_o === 1'b1) n_save++;
      if (config_load_o === 1'b1) n_load++;
      if (cycles == 5000) begin
         err_total++;
         wrap_up();
      end
   end
   task check16(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check16
   task settle();
      repeat (3) @(posedge clock_i);
      #2;
   endtask : settle
   task cmd(input logic [15:0] w);
      host.write_word(w);
      settle();
   endtask : cmd
   task cmd_op(input logic [15:0] w, input logic [15:0] op);
      host.write_word(w);
      host.write_word(op);
      settle();
   endtask : cmd_op
   task query(input logic [15:0] w, output logic [15:0] r);
      host.write_word(w);
      host.read_word(r);
      settle();
   endtask : query
   task t_reset();
      check16(host_flow_flags_o, 16'h0001);
      check16(port_rdata_o, 16'h0000);
      check16({11'h000, windowed_mode_o, edge_mode_o, dead_time_o}, 16'h0000);
      $display("test reset done");
   endtask : t_reset
   task t_permit();
      int i;
      int zeros;
      zeros = 0;
      host.write_word(16'h03A5);
      for (i = 0; i < 4; i++) begin
         if (host_flow_flags_o[0] === 1'b0) zeros++;
         @(posedge clock_i);
         #2;
      end
      check16(16'(zeros), 16'h0001);
      check16(host_flow_flags_o, 16'h0001);
      $display("test permit done");
   endtask : t_permit
   task t_classes();
      int i;
      int c;
      for (i = 0; i < 8; i++) begin
         c = n_clear;
         cmd({s_ops[i], 8'hA5});
         check16(16'(n_clear - c), 16'h0001);
      end
      for (i = 0; i < 3; i++) begin
         c = n_clear;
         cmd({n_ops[i], 8'h5A});
         check16(16'(n_clear - c), 16'h0000);
      end
      check16(16'({n_save[7:0], n_load[7:0]}), 16'h0101);
      $display("test classes done");
   endtask : t_classes
   task t_mode();
      cmd(16'h0000);
      check16({13'h0000, windowed_mode_o, keep_token_o, auto_reject_o}, 16'h0007);
      query(16'h0200, rd);
      check16({15'h0000, rd[0]}, 16'h0001);
      cmd(16'h1400);
      check16({15'h0000, subtract_o}, 16'h0001);
      cmd(16'h1500);
      check16({15'h0000, subtract_o}, 16'h0000);
      cmd(16'h1400);
      cmd(16'h0100);
      check16({13'h0000, windowed_mode_o, auto_reject_o, subtract_o}, 16'h0000);
      query(16'h0200, rd);
      check16({15'h0000, rd[0]}, 16'h0000);
      cmd(16'h0300);
      check16({15'h0000, keep_token_o}, 16'h0001);
      cmd(16'h0400);
      check16({15'h0000, keep_token_o}, 16'h0000);
      cmd(16'h0800);
      check16({15'h0000, boot_custom_o}, 16'h0001);
      cmd(16'h0900);
      check16({15'h0000, boot_custom_o}, 16'h0000);
      $display("test mode done");
   endtask : t_mode
   task t_trig();
      int i;
      int c;
      c = n_clear;
      cmd_op(16'h1000, 16'hFABC);
      cmd_op(16'h1100, 16'h0123);
      cmd_op(16'h1200, 16'h0FFF);
      cmd_op(16'h1300, 16'h0001);
      cmd(16'h1400);
      host.write_word(16'h1600);
      for (i = 0; i < 5; i++) begin
         host.read_word(rd);
         if (i < 4) check16(rd, trig_exp[i]);
         else check16({15'h0000, rd[0]}, 16'h0001);
         if (i == 1) begin
            check16({15'h0000, host_flow_flags_o[0]}, 16'h0000);
            host.write_blind(16'h0000);
         end
      end
      settle();
      check16(host_flow_flags_o, 16'h0001);
      check16({15'h0000, windowed_mode_o}, 16'h0000);
      check16(16'(n_clear - c), 16'h0005);
      $display("test trigger done");
   endtask : t_trig
   task t_edge();
      int c;
      c = n_clear;
      cmd_op(16'h2200, 16'h0002);
      check16({14'h0000, edge_mode_o}, 16'h0002);
      query(16'h2300, rd);
      check16({14'h0000, rd[1:0]}, 16'h0002);
      cmd_op(16'h2800, 16'h0003);
      check16({14'h0000, dead_time_o}, 16'h0003);
      query(16'h2900, rd);
      check16({14'h0000, rd[1:0]}, 16'h0003);
      cmd_op(16'h2400, 16'h0001);
      cmd_op(16'h2500, 16'h1234);
      query(16'h2600, rd);
      check16(rd, 16'h1234);
      check16(host_flow_flags_o, 16'h0001);
      check16(16'(n_clear - c), 16'h0004);
      $display("test edge done");
   endtask : t_edge
   task t_target();
      cmd(16'h001F);
      check16({7'h00, target_valid_o, target_o}, 16'h011F);
      cmd(16'h0020);
      check16({7'h00, target_valid_o, target_o}, 16'h0020);
      $display("test target done");
   endtask : t_target
   task t_reset_mid();
      host.write_word(16'h1600);
      host.read_word(rd);
      @(posedge clock_i);
      #2;
      reset_i = 1'b1;
      repeat (2) @(posedge clock_i);
      #2;
      reset_i = 1'b0;
      check16(host_flow_flags_o, 16'h0001);
      check16(port_rdata_o, 16'h0000);
      check16({14'h0000, edge_mode_o}, 16'h0000);
      cmd(16'h0000);
      check16({15'h0000, windowed_mode_o}, 16'h0001);
      $display("test mid reset done");
   endtask : t_reset_mid
   initial begin
      repeat (3) @(posedge clock_i);
      #2;
      reset_i = 1'b0;
      t_reset();
      t_permit();
      t_classes();
      t_mode();
      t_trig();
      t_edge();
      t_target();
      t_reset_mid();
      wrap_up();
   end
endmodule : opcode_handshake_interpreter_bench

// [opcode_pkg.sv]
package opcode_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WRITE = 2'b01,
      ST_READ = 2'b10
   } phase_t;
   typedef struct packed {
      logic [7:0] operation_selector;
      logic [7:0] target_selector;
   } command_word_t;
   typedef struct packed {
      logic windowed;
      logic keep_token;
      logic auto_reject;
      logic subtract;
      logic boot_custom;
      logic [11:0] span;
      logic [11:0] shift;
      logic [11:0] search;
      logic [11:0] discard;
      logic [1:0] edge_mode;
      logic [1:0] edge_res;
      logic [15:0] pair_res;
      logic [1:0] dead;
   } setup_t;
   typedef struct packed {
      phase_t phase;
      logic [7:0] op;
      logic [2:0] idx;
      logic [2:0] count;
      logic write_permit_bit;
      logic read_permit_bit;
      logic [15:0] rd_word;
      logic clear_data;
      logic save_pulse;
      logic load_custom_pulse;
      logic [7:0] target;
      logic target_valid;
      setup_t setup;
   } state_t;
endpackage : opcode_pkg

// [vme_host_model.sv]
`timescale 1ns/1ps
module vme_host_model (
   input wire logic clock_i,
   input wire logic [15:0] host_flow_flags_i,
   input wire logic [15:0] port_rdata_i,
   output logic port_write_o,
   output logic [15:0] port_wdata_o,
   output logic port_read_o
);
   int timeouts = 0;
   initial begin
      port_write_o = 1'b0;
      port_wdata_o = 16'h0000;
      port_read_o = 1'b0;
   end
   // bounded poll so a stuck flag cannot hang the host
   task automatic wait_permit(input int bitpos);
      int n;
      n = 0;
      @(posedge clock_i);
      #2;
      while (host_flow_flags_i[bitpos] !== 1'b1 && n < 50) begin
         @(posedge clock_i);
         #2;
         n++;
      end
      if (n >= 50) timeouts++;
   endtask : wait_permit
   task automatic write_word(input logic [15:0] w);
      wait_permit(0);
      port_write_o = 1'b1;
      port_wdata_o = w;
      @(posedge clock_i);
      #2;
      port_write_o = 1'b0;
      port_wdata_o = ~w; // released bus must not look valid
   endtask : write_word
   // breaks the permit check on purpose, only when a test asks for it
   task automatic write_blind(input logic [15:0] w);
      @(posedge clock_i);
      #2;
      port_write_o = 1'b1;
      port_wdata_o = w;
      @(posedge clock_i);
      #2;
      port_write_o = 1'b0;
      port_wdata_o = ~w;
   endtask : write_blind
   task automatic read_word(output logic [15:0] r);
      wait_permit(1);
      port_read_o = 1'b1;
      // word stands unchanged up to the taking edge
      r = port_rdata_i;
      @(posedge clock_i);
      #2;
      port_read_o = 1'b0;
   endtask : read_word
endmodule : vme_host_model
